// ---- design/tcwd_trip_circuit_watch.sv ----
// trip circuit watch: supervision timers, alarm outputs, breaker status, APB registers
//
// Operation
// RULE_01: drop-off output rises at once on energised input, falls after 400 ms low.
// RULE_02: while drop-off output is high, relay energised and alarm path reset; the indicator stays latched.
// RULE_03: alarm request is the inverted drop-off output; it sets indicator and alarm flag.
// RULE_04: the request passes a 50 ms pick-up delay before setting indicator or alarm.
// RULE_05: two-input scheme alarms only when both inputs are low, same delays.
// RULE_06: two-input scheme: input 1 normally-open, input 2 normally-closed, gives breaker status.
// RULE_07: breaker normally-closed contact always presents the complement of normally-open contact.
// RULE_08: an input held low beyond the drop-off delay alarms even if shorted by latched contact.
// RULE_09: reset clears timers and indicator, relay off; indicator then clears only by command.
`timescale 1ns/1ps
module tcwd_trip_circuit_watch
  import tcwd_pkg::*;
#(
  parameter int unsigned DROP_CYCLES = DROP_OFF_CYCLES,
  parameter int unsigned PICK_CYCLES = PICK_UP_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        opto_in1,
  input  wire logic        opto_in2,
  output logic             relay_energise,
  output logic             indicator_led,
  output logic             user_alarm,
  output logic             cb_closed,
  output logic             cb_status_fault,
  output logic             irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  tcwd_ctrl_t       ctrl;
  logic [EVT_W-1:0] int_stat;
  logic [EVT_W-1:0] int_mask;
  logic [EVT_W-1:0] events;
  logic             sense;
  logic             drop_out;
  logic             alarm_req;
  logic             pick_out;
  logic             pick_out_d;
  logic             drop_out_d;
  logic             both_mode;
  logic             cb_valid;
  logic             cb_closed_d;
  logic             cb_fault_d;
  logic             wr_access;
  logic             rd_setup;
  logic             clr_cmd;
  logic             addr_ok;
  tcwd_status_t     status;
  logic [31:0]      next_prdata;

  // ****************************************************************
  // register address decode
  // ****************************************************************

  // returns true for an offset that holds a register
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_CMD) ||
           (a == OFS_INT_STAT) || (a == OFS_INT_MASK);
  endfunction

  // zero wait states keep the bus slave trivial; errors only in access phase
  assign addr_ok   = is_mapped(paddr);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;
  assign wr_access = psel && penable && pwrite && addr_ok;
  assign rd_setup  = psel && !penable && !pwrite;
  assign clr_cmd   = wr_access && (paddr == OFS_CMD) && pwdata[CMD_CLR_IND_BIT];

  // ****************************************************************
  // supervision sense and timers
  // ****************************************************************

  // two-input scheme watches current through either contact path
  assign both_mode = (ctrl.scheme == SCHEME_TWO);
  assign sense     = both_mode ? (opto_in1 || opto_in2) : opto_in1; // [RULE_05] [RULE_08]

  tcwd_drop_off_timer #(
    .DELAY     (DROP_CYCLES)
  ) u_drop (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .enable    (ctrl.enable),
    .sense     (sense),
    .timer_out (drop_out)
  );

  // alarm request is the inverse of the drop-off timer, gated by the enable bit
  assign alarm_req = ctrl.enable && !drop_out;          // [RULE_03]

  tcwd_pick_up_timer #(
    .DELAY     (PICK_CYCLES)
  ) u_pick (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .request   (alarm_req),
    .timer_out (pick_out)
  );

  // ****************************************************************
  // alarm outputs
  // ****************************************************************

  // normally closed relay: energised (contact open) while supervision is healthy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_energise <= 1'b0;                          // [RULE_09]
    end else if (ce) begin
      relay_energise <= drop_out;                      // [RULE_02]
    end
  end

  // user alarm follows the delayed request and drops while supervision is healthy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_alarm <= 1'b0;
    end else if (ce) begin
      if (drop_out) begin
        user_alarm <= 1'b0;                            // [RULE_02]
      end else if (pick_out) begin
        user_alarm <= 1'b1;                            // [RULE_03] [RULE_04]
      end
    end
  end

  // latching indicator: set wins over the clear command in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_led <= 1'b0;                           // [RULE_09]
    end else if (ce) begin
      if (pick_out) begin
        indicator_led <= 1'b1;                         // [RULE_03] [RULE_04]
      end else if (clr_cmd) begin
        indicator_led <= 1'b0;                         // [RULE_09]
      end
    end
  end

  // ****************************************************************
  // breaker status from the two auxiliary contacts
  // ****************************************************************

  // valid only when the contacts disagree, since they must be complements
  assign cb_valid = opto_in1 ^ opto_in2;               // [RULE_07]

  // a matching pair holds the last good position and raises the fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_closed       <= 1'b0;
      cb_status_fault <= 1'b0;
    end else if (ce) begin
      if (both_mode && ctrl.status_both) begin
        cb_status_fault <= !cb_valid;                  // [RULE_07]
        if (cb_valid) begin
          cb_closed <= opto_in1;                       // [RULE_06]
        end
      end else begin
        cb_status_fault <= 1'b0;
        cb_closed       <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // event detection
  // ****************************************************************

  // previous values for edge detection of the event sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pick_out_d  <= 1'b0;
      drop_out_d  <= 1'b0;
      cb_closed_d <= 1'b0;
      cb_fault_d  <= 1'b0;
    end else if (ce) begin
      pick_out_d  <= pick_out;
      drop_out_d  <= drop_out;
      cb_closed_d <= cb_closed;
      cb_fault_d  <= cb_status_fault;
    end
  end

  assign events[EVT_ALARM_SET] = pick_out && !pick_out_d;
  assign events[EVT_ALARM_CLR] = drop_out && !drop_out_d;
  assign events[EVT_CB_CHANGE] = cb_closed ^ cb_closed_d;
  assign events[EVT_CB_FAULT]  = cb_status_fault && !cb_fault_d;

  // ****************************************************************
  // control, mask and interrupt status registers
  // ****************************************************************

  // control register steers scheme and status derivation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (ce && wr_access && (paddr == OFS_CTRL)) begin
      ctrl <= tcwd_ctrl_t'(pwdata[$bits(tcwd_ctrl_t)-1:0]);
    end
  end

  // interrupt mask, same layout as the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= INT_MASK_RESET;
    end else if (ce && wr_access && (paddr == OFS_INT_MASK)) begin
      int_mask <= pwdata[EVT_W-1:0];
    end
  end

  // sticky bits cleared by writing one; a new event in the same cycle wins
  for (genvar i = 0; i < EVT_W; i++) begin : g_evt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        int_stat[i] <= 1'b0;
      end else if (ce) begin
        if (events[i]) begin
          int_stat[i] <= 1'b1;
        end else if (wr_access && (paddr == OFS_INT_STAT) && pwdata[i]) begin
          int_stat[i] <= 1'b0;
        end
      end
    end
  end

  // level interrupt while any unmasked status bit stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(int_stat & int_mask);
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************

  // live state as seen by software
  assign status = '{in2: opto_in2, in1: opto_in1, cb_fault: cb_status_fault,
                    cb_closed: cb_closed, user_alarm: user_alarm,
                    indicator: indicator_led, relay_on: relay_energise,
                    drop_off_out: drop_out};

  // read mux; write-only command and unmapped offsets read as zero
  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      OFS_CTRL:     next_prdata[$bits(tcwd_ctrl_t)-1:0] = ctrl;
      OFS_STATUS:   next_prdata[$bits(tcwd_status_t)-1:0] = status;
      OFS_INT_STAT: next_prdata[EVT_W-1:0] = int_stat;
      OFS_INT_MASK: next_prdata[EVT_W-1:0] = int_mask;
      default:      next_prdata = 32'h0;
    endcase
  end

  // data is captured in the setup phase so that it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (ce && rd_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule

// ---- design/tcwd_pkg.sv ----
// package of constants and types for the trip circuit watch block
package tcwd_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned CYCLES_PER_MS    = CLK_MHZ * 1000;
  localparam int unsigned DROP_OFF_MS      = 400;
  localparam int unsigned PICK_UP_MS       = 50;
  localparam int unsigned DROP_OFF_CYCLES  = DROP_OFF_MS * CYCLES_PER_MS;
  localparam int unsigned PICK_UP_CYCLES   = PICK_UP_MS * CYCLES_PER_MS;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CMD      = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;

  // ****************************************************************
  // field positions and encodings
  // ****************************************************************
  localparam int unsigned CMD_CLR_IND_BIT = 0;
  localparam logic [1:0]  SCHEME_ONE      = 2'h0;
  localparam logic [1:0]  SCHEME_TWO      = 2'h1;
  localparam logic [1:0]  SCHEME_THREE    = 2'h2;
  localparam int unsigned EVT_ALARM_SET   = 0;
  localparam int unsigned EVT_ALARM_CLR   = 1;
  localparam int unsigned EVT_CB_CHANGE   = 2;
  localparam int unsigned EVT_CB_FAULT    = 3;
  localparam int unsigned EVT_W           = 4;

  // ****************************************************************
  // register layouts and reset values
  // ****************************************************************
  typedef struct packed {
    logic       status_both;
    logic [1:0] scheme;
    logic       enable;
  } tcwd_ctrl_t;

  typedef struct packed {
    logic in2;
    logic in1;
    logic cb_fault;
    logic cb_closed;
    logic user_alarm;
    logic indicator;
    logic relay_on;
    logic drop_off_out;
  } tcwd_status_t;

  localparam tcwd_ctrl_t     CTRL_RESET     = '{status_both: 1'b0, scheme: 2'h0, enable: 1'b1};
  localparam logic [EVT_W-1:0] INT_MASK_RESET = 4'h0;

endpackage

// ---- design/tcwd_drop_off_timer.sv ----
// delayed drop-off timer: follows its input up at once, falls after a held low
`timescale 1ns/1ps
module tcwd_drop_off_timer
  import tcwd_pkg::*;
#(
  parameter int unsigned DELAY = DROP_OFF_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic sense,
  output logic      timer_out
);

  logic [31:0] cnt;

  // rises with sense, falls after DELAY consecutive low cycles or at once when disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out <= 1'b0;
      cnt       <= 32'h0;
    end else if (ce) begin
      if (!enable) begin
        timer_out <= 1'b0;
        cnt       <= 32'h0;
      end else if (sense) begin
        timer_out <= 1'b1;                     // [RULE_01]
        cnt       <= 32'h0;
      end else if (timer_out) begin
        if (cnt == DELAY - 1) begin
          timer_out <= 1'b0;                   // [RULE_01] [RULE_08]
          cnt       <= 32'h0;
        end else begin
          cnt <= cnt + 32'h1;
        end
      end
    end
  end

endmodule

// ---- design/tcwd_pick_up_timer.sv ----
// delayed pick-up timer: rises after a held high, falls with its input at once
`timescale 1ns/1ps
module tcwd_pick_up_timer
  import tcwd_pkg::*;
#(
  parameter int unsigned DELAY = PICK_UP_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic request,
  output logic      timer_out
);

  logic [31:0] cnt;

  // a short request is dropped, so supply recovery glitches never reach the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out <= 1'b0;
      cnt       <= 32'h0;
    end else if (ce) begin
      if (!request) begin
        timer_out <= 1'b0;
        cnt       <= 32'h0;
      end else if (!timer_out) begin
        if (cnt == DELAY - 1) begin
          timer_out <= 1'b1;                   // [RULE_04]
        end else begin
          cnt <= cnt + 32'h1;
        end
      end
    end
  end

endmodule

// ---- verification/tcwd_trip_circuit_watch_props.sv ----
// port checker for the trip circuit watch block
`timescale 1ns/1ps
module tcwd_props
  import tcwd_pkg::*;
#(
  parameter int unsigned DROP_CYCLES = 40,
  parameter int unsigned PICK_CYCLES = 10
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic       opto_in1,
  input wire logic       opto_in2,
  input wire logic       relay_energise,
  input wire logic       indicator_led,
  input wire logic       user_alarm,
  input wire logic       cb_closed,
  input wire logic       cb_status_fault
);
  logic [15:0] low1;
  logic [15:0] both_low;
  logic [15:0] rly_low;

  // stretch counters saturate so a long run never wraps into a false match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low1     <= '0;
      both_low <= '0;
      rly_low  <= '0;
    end else begin
      low1     <= opto_in1 ? '0 : low1 + {15'h0, ~&low1};
      both_low <= (opto_in1 | opto_in2) ? '0 : both_low + {15'h0, ~&both_low};
      rly_low  <= relay_energise ? '0 : rly_low + {15'h0, ~&rly_low};
    end
  end

  default clocking cb_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RISE: assert property (opto_in1 |-> ##2 relay_energise)
    else $error("relay not energised after live input");
  AST_HOLD: assert property ($fell(relay_energise) |-> low1 > DROP_CYCLES)
    else $error("relay dropped before the drop-off delay");
  AST_DROP: assert property (both_low == DROP_CYCLES + 1 |-> !relay_energise)
    else $error("relay still energised after a long low input");
  AST_QUIET: assert property (relay_energise |-> !user_alarm)
    else $error("user alarm while relay energised");
  AST_PICK: assert property ($rose(user_alarm) |-> rly_low >= PICK_CYCLES - 1)
    else $error("user alarm before the pick-up delay");
  AST_LATE: assert property (rly_low == PICK_CYCLES + 3 |-> user_alarm)
    else $error("user alarm missing after the pick-up delay");
  AST_LED: assert property ($rose(user_alarm) |-> indicator_led)
    else $error("indicator not set with the user alarm");
  AST_LATCH: assert property ($fell(indicator_led) |->
    $past(psel && penable && pwrite && paddr == OFS_CMD && pwdata[0]))
    else $error("indicator cleared without a command");
  AST_CB: assert property ($rose(cb_closed) |-> $past(opto_in1 && !opto_in2))
    else $error("breaker closed without matching contacts");

  COV_ALARM: cover property ($rose(user_alarm));
  COV_CLEAR: cover property ($fell(indicator_led));
  COV_FAULT: cover property ($rose(cb_status_fault));
endmodule

bind tcwd_trip_circuit_watch tcwd_props #(
  .DROP_CYCLES(DROP_CYCLES),
  .PICK_CYCLES(PICK_CYCLES)
) i_tcwd_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .opto_in1,
  .opto_in2, .relay_energise, .indicator_led, .user_alarm, .cb_closed, .cb_status_fault);

// ---- verification/tcwd_breaker_model.sv ----
// breaker contacts and trip coil as seen at the two opto inputs
`timescale 1ns/1ps
module tcwd_breaker_model (
  input  wire logic pclk,
  input  wire logic two_in,
  input  wire logic cb_pos,
  input  wire logic coil_ok,
  input  wire logic trip_short,
  output logic      opto_in1,
  output logic      opto_in2
);
  initial begin
    opto_in1 = 1'b0;
    opto_in2 = 1'b0;
  end

  // an unwired second opto reads de-energised; a shorting trip contact starves input 1
  always @(posedge pclk) begin
    opto_in1 <= coil_ok & ~trip_short & (cb_pos | ~two_in);
    opto_in2 <= coil_ok & ~cb_pos & two_in;
  end
endmodule

// ---- verification/test_tcwd_trip_circuit_watch.sv ----
// self-checking bench for the trip circuit watch block
`timescale 1ns/1ps
module test_tcwd_trip_circuit_watch;
  import tcwd_pkg::*;
  localparam int DROP = 40;
  localparam int PICK = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        opto_in1, opto_in2, relay_energise, indicator_led, user_alarm;
  logic        cb_closed, cb_status_fault, irq, two_in, cb_pos, coil_ok, trip_short;
  int          err_total, tests_run;

  tcwd_trip_circuit_watch #(.DROP_CYCLES(DROP), .PICK_CYCLES(PICK))
    i_tcwd_trip_circuit_watch (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .opto_in1, .opto_in2, .relay_energise,
    .indicator_led, .user_alarm, .cb_closed, .cb_status_fault, .irq);
  tcwd_breaker_model i_tcwd_breaker_model (.pclk, .two_in, .cb_pos, .coil_ok,
    .trip_short, .opto_in1, .opto_in2);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; read data and error are taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for an output level; running out counts as a failure
  task automatic wait_on(input int sel, input logic lvl, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      @(posedge pclk);
      s = sel == 0 ? relay_energise : sel == 1 ? user_alarm : sel == 2 ? irq : cb_closed;
      if (s === lvl) return;
    end
    err_total++;
    wrap_up();
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    two_in = 1'b0;
    cb_pos = 1'b1;
    coil_ok = 1'b1;
    trip_short = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    chk(relay_energise, 32'h0);
    presetn <= 1'b1;
    // ********
    // healthy circuit after reset
    // ********
    apb(0, OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(0, OFS_INT_MASK, 32'h0);
    chk(rd, 32'h0);
    wait_on(0, 1, 4);
    apb(0, OFS_STATUS, 32'h0);
    chk(rd, 32'h43);
    // ********
    // short dip, then a latched trip contact
    // ********
    apb(1, OFS_CTRL, 32'h5);
    trip_short <= 1'b1;
    repeat (DROP - 10) @(posedge pclk);
    trip_short <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(relay_energise, 32'h1);
    trip_short <= 1'b1;
    wait_on(0, 0, DROP + 4);
    chk(user_alarm, 32'h0);
    wait_on(1, 1, PICK + 4);
    chk(indicator_led, 32'h1);
    chk(irq, 32'h0);
    apb(0, OFS_INT_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1, OFS_INT_MASK, 32'h1);
    wait_on(2, 1, 4);
    apb(1, OFS_INT_STAT, 32'h3);
    wait_on(2, 0, 4);
    // ********
    // restore, latch and clear command
    // ********
    trip_short <= 1'b0;
    wait_on(0, 1, 4);
    chk(user_alarm, 32'h0);
    chk(indicator_led, 32'h1);
    apb(1, OFS_CMD, 32'h1);
    apb(0, OFS_CMD, 32'h0);
    chk(rd, 32'h0);
    chk(indicator_led, 32'h0);
    // ********
    // two-input scheme with breaker status
    // ********
    apb(1, OFS_CTRL, 32'hB);
    two_in <= 1'b1;
    wait_on(3, 1, 6);
    cb_pos <= 1'b0;
    wait_on(3, 0, 6);
    chk(cb_status_fault, 32'h0);
    trip_short <= 1'b1;
    repeat (DROP + 10) @(posedge pclk);
    chk(relay_energise, 32'h1);
    coil_ok <= 1'b0;
    wait_on(0, 0, DROP + 4);
    chk(cb_status_fault, 32'h1);
    wait_on(1, 1, PICK + 4);
    apb(0, 8'h20, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    // ********
    // reset in mid-run
    // ********
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(indicator_led, 32'h0);
    chk(relay_energise, 32'h0);
    presetn <= 1'b1;
    wait_on(1, 1, PICK + 4);
    wrap_up();
  end
endmodule
